/* File: biu_model.sv */
/*
 * Behavioural bus interface unit and data RAM bank facing the cache controller.
 * Assumes the bench pulses go for one cycle per linefill, off the falling edge.
 */
`timescale 1ns/100ps
module biu_model
    import cache_ctrl_pkg::*;
(
    input  wire logic            core_clk,
    input  wire logic            sys_rst,
    input  wire logic            go,
    input  wire logic            slow,
    input  wire logic [3:0]      abortMask,
    input  wire logic [DW_W-1:0] base,
    input  wire logic            biuBeatReady,
    input  wire logic            ramWe,
    input  wire logic [DW_W-1:0] ramData,
    input  wire logic [7:0]      ramPar,
    output logic      [DW_W-1:0] biuBeatData,
    output logic                 biuBeatAbort,
    output logic                 biuBeatValid,
    output int                   parErrs
);
    int   left;
    int   idx;
    logic took;
    logic kick;
    ////////////////////////////////////////////////////////////////////////////
    // Handshake seen at the rising edge, acted on at the next falling one
    always @(posedge core_clk) begin
        took <= biuBeatValid && biuBeatReady;
        kick <= go;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Beats held until taken; idle lines flip so stale data never looks valid
    always @(negedge core_clk) begin
        if (sys_rst) begin
            left = 0;
            parErrs = 0;
            biuBeatValid <= 1'b0;
            biuBeatAbort <= 1'b0;
            biuBeatData  <= 64'h0;
        end else begin
            if (took) left = left - 1;
            if (kick) left = BEATS;
            idx = BEATS - left;
            if (left > 0 && !(slow && took)) begin
                biuBeatValid <= 1'b1;
                biuBeatData  <= base + 64'(idx);
                biuBeatAbort <= abortMask[idx[1:0]];
            end else begin
                biuBeatValid <= 1'b0;
                biuBeatAbort <= ~biuBeatAbort;
                biuBeatData  <= ~biuBeatData;
            end
            // RAM side checks all eight byte parities on each write; the controller asserts byte 0 only
            if (ramWe === 1'b1) begin
                for (int i = 0; i < 8; i++)
                    if ((^{ramPar[i], ramData[8*i+:8]}) !== 1'b1) parErrs++;
            end
        end
    end
endmodule

/* File: cache_ctrl_pkg.sv */
/*
 * Constants shared by the cache size, abort and parity controller.
 * Assumes a single core clock; straps are stable before reset is released.
 */
package cache_ctrl_pkg;
    localparam int        WAYS        = 4;
    localparam int        BEATS       = 4;
    localparam int        LINE_BYTES  = 32;
    localparam int        TAG_W       = 22;
    localparam int        DW_W        = 64;
    localparam int        ADDR_W      = 32;
    localparam int        MAX_IDX_W   = 10;
    localparam int        MIN_IDX_W   = 5;
    localparam logic [3:0] SIZE_MIN   = 4'h3;
    localparam logic [3:0] SIZE_MAX   = 4'h8;
    localparam logic [3:0] IDXW_RST   = 4'h0;
    localparam logic [1:0] BEAT_LAST  = 2'h3;
    localparam logic [1:0] BEAT_RST   = 2'h0;
    localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
endpackage

/* File: cache_size_abort_parity_ctrl.sv */
/*
 * Linefill, castout, abort and parity control for one instruction and one
 * data cache. Assumes the bus interface unit returns fill beats critical
 * first, and the RAM banks take one write per beat.
 */
`timescale 1ns/100ps
module cache_size_abort_parity_ctrl
    import cache_ctrl_pkg::*;
#(
    parameter int FIFO_DEPTH = 4
) (
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    input  wire logic [3:0]        data_cache_size_strap,
    input  wire logic [3:0]        instr_cache_size_strap,
    input  wire logic              dFillReq,
    input  wire logic              iFillReq,
    input  wire logic              iFillIsPrefetch,
    input  wire logic [ADDR_W-1:0] fillAddr,
    input  wire logic              fillHitBuf,
    input  wire logic [DW_W-1:0]   biuBeatData,
    input  wire logic              biuBeatAbort,
    input  wire logic              biuBeatValid,
    output logic                   biuBeatReady,
    input  wire logic              iExecuted,
    input  wire logic              victimValid,
    input  wire logic              victimDirty,
    input  wire logic              cleanReq,
    input  wire logic              castoutDone,
    input  wire logic              castoutAbort,
    input  wire logic              dAccessValid,
    input  wire logic [TAG_W-1:0]  tagIn,
    output logic [3:0]             dIdxWidth,
    output logic [3:0]             iIdxWidth,
    output logic                   dZeroKb,
    output logic                   iZeroKb,
    output logic                   fillBusy,
    output logic                   fillDone,
    output logic                   lineValid,
    output logic                   bufServe,
    output logic                   dPreciseAbort,
    output logic                   iPreciseAbort,
    output logic                   dImpreciseAbort,
    output logic [ADDR_W-1:0]      data_fault_address_reg,
    output logic [ADDR_W-1:0]      instr_fault_address_reg,
    output logic                   castoutStart,
    output logic [TAG_W-1:0]       instr_tag_write_bus,
    output logic [2:0]             instr_tag_parity_out,
    output logic [DW_W-1:0]        instr_data_write_bus,
    output logic [7:0]             instr_data_parity_out,
    output logic                   iRamWe,
    output logic [TAG_W-1:0]       data_tag_write_bus,
    output logic [2:0]             data_tag_parity_out,
    output logic [DW_W-1:0]        data_data_write_bus,
    output logic [7:0]             data_data_parity_out,
    output logic                   dRamWe
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_FILL = 3'b010,
        ST_DONE = 3'b100
    } fill_state_t;

    ////////////////////////////////////////////////////////////////////////
    // Strap decode: index width 5..10 or 0 for a 0KB cache
    function automatic logic [3:0] idxWidth(input logic [3:0] s);
        if (s >= SIZE_MIN && s <= SIZE_MAX) return 4'(s) + 4'h2;
        return IDXW_RST;
    endfunction

    fill_state_t        state_reg, state_next;
    logic [1:0]         beat_reg;
    logic               isData_reg;
    logic               isPref_reg;
    logic               abortSeen_reg;
    logic [ADDR_W-1:0]  addr_reg;
    logic               strapDone_reg;
    logic [DW_W-1:0]    lineBuf [BEATS];
    logic               castPend_reg;
    logic               castErr_reg;

    wire [64:0] fifoOut;
    wire        fifoValid;
    wire        fifoInReady;
    wire        beatTake  = (state_reg == ST_FILL) && fifoValid;
    wire        beatAbort = fifoOut[64];
    wire        firstBeat = beat_reg == BEAT_RST;
    wire        lastBeat  = beat_reg == BEAT_LAST;
    wire        curZero   = isData_reg ? dZeroKb : iZeroKb;
    wire        startReq  = (dFillReq || iFillReq) && !fillHitBuf;
    wire        ramWrite  = beatTake && !curZero && !abortSeen_reg && !beatAbort;
    // First beat or streamed beat abort is visible to the core
    wire        sigAbort  = beatTake && beatAbort && (firstBeat || !abortSeen_reg);
    wire        castNeed  = dFillReq && (victimValid && victimDirty) || cleanReq;
    wire [7:0]  dPar;
    wire [2:0]  tPar;

    ////////////////////////////////////////////////////////////////////////
    // Fill beats enter through a small FIFO; biuBeatReady is fifoInReady registered, so the BIU stalls the cycle after it fills
    fill_fifo #(.W(65), .DEPTH(FIFO_DEPTH)) uFifo (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .inData   ({biuBeatAbort, biuBeatData}),
        .inValid  (biuBeatValid && biuBeatReady), // Only beats the BIU sees taken
        .inReady  (fifoInReady),
        .outData  (fifoOut),
        .outValid (fifoValid),
        .outReady (state_reg == ST_FILL)
    );
    parity_gen #(.W(DW_W))  uDataPar (.busIn(fifoOut[63:0]), .parOut(dPar));
    parity_gen #(.W(TAG_W)) uTagPar  (.busIn(tagIn), .parOut(tPar));

    ////////////////////////////////////////////////////////////////////////
    // Straps sampled once, first cycle after reset; held thereafter
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            strapDone_reg <= 1'b0;
            dIdxWidth     <= IDXW_RST;
            iIdxWidth     <= IDXW_RST;
            dZeroKb       <= 1'b1;
            iZeroKb       <= 1'b1;
        end else if (!strapDone_reg) begin
            strapDone_reg <= 1'b1;
            dIdxWidth     <= idxWidth(data_cache_size_strap);
            iIdxWidth     <= idxWidth(instr_cache_size_strap);
            dZeroKb       <= idxWidth(data_cache_size_strap) == IDXW_RST;
            iZeroKb       <= idxWidth(instr_cache_size_strap) == IDXW_RST;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fill sequencer
    always_comb begin
        case (state_reg)
            ST_IDLE: state_next = (startReq && strapDone_reg) ? ST_FILL : ST_IDLE;
            ST_FILL: state_next = (beatTake && lastBeat) ? ST_DONE : ST_FILL;
            ST_DONE: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_reg     <= ST_IDLE;
            beat_reg      <= BEAT_RST;
            isData_reg    <= 1'b0;
            isPref_reg    <= 1'b0;
            abortSeen_reg <= 1'b0;
            addr_reg      <= ADDR_RST;
        end else begin
            state_reg <= state_next;
            if (state_reg == ST_IDLE && state_next == ST_FILL) begin
                beat_reg      <= BEAT_RST;
                isData_reg    <= dFillReq;
                isPref_reg    <= !dFillReq && iFillIsPrefetch;
                abortSeen_reg <= 1'b0;
                addr_reg      <= fillAddr;
            end else if (beatTake) begin
                beat_reg      <= beat_reg + 2'h1;
                abortSeen_reg <= abortSeen_reg || beatAbort;
            end
        end
    end

    // Line buffer keeps the filling line for streaming and 0KB reuse
    always_ff @(posedge core_clk) begin
        if (beatTake) lineBuf[beat_reg] <= fifoOut[63:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // Status and abort reporting; all registered
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            fillBusy      <= 1'b0;
            fillDone      <= 1'b0;
            lineValid     <= 1'b0;
            bufServe      <= 1'b0;
            dPreciseAbort <= 1'b0;
            iPreciseAbort <= 1'b0;
            biuBeatReady  <= 1'b0;
            data_fault_address_reg  <= ADDR_RST;
            instr_fault_address_reg <= ADDR_RST;
        end else begin
            biuBeatReady <= fifoInReady;
            fillBusy     <= state_next == ST_FILL;
            fillDone     <= state_reg == ST_FILL && state_next == ST_DONE;
            if (state_reg == ST_FILL && state_next == ST_DONE)
                lineValid <= !(abortSeen_reg || beatAbort);
            else if (state_next == ST_FILL)
                lineValid <= 1'b0;
            // Served from buffer without another linefill
            bufServe <= (dFillReq || iFillReq) && fillHitBuf && lineValid;
            dPreciseAbort <= sigAbort && isData_reg;
            iPreciseAbort <= sigAbort && !isData_reg && !isPref_reg && iExecuted;
            if (sigAbort && isData_reg)
                data_fault_address_reg <= addr_reg;
            if (sigAbort && !isData_reg && !isPref_reg && iExecuted)
                instr_fault_address_reg <= addr_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Castouts: data cache only, whole line, abort reported later
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            castoutStart    <= 1'b0;
            castPend_reg    <= 1'b0;
            castErr_reg     <= 1'b0;
            dImpreciseAbort <= 1'b0;
        end else begin
            castoutStart <= castNeed && !castPend_reg && !dZeroKb;
            if (castNeed && !castPend_reg && !dZeroKb) castPend_reg <= 1'b1;
            else if (castoutDone) castPend_reg <= 1'b0;
            // Set wins over the clear taken on the next data access
            if (castoutDone && castoutAbort) castErr_reg <= 1'b1;
            else if (dAccessValid) castErr_reg <= 1'b0;
            dImpreciseAbort <= dAccessValid && castErr_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // RAM-facing buses: zero in reset, parity aligned with its data
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            instr_data_write_bus  <= '0;
            instr_data_parity_out <= '0;
            instr_tag_write_bus   <= '0;
            instr_tag_parity_out  <= '0;
            iRamWe                <= 1'b0;
            data_data_write_bus   <= '0;
            data_data_parity_out  <= '0;
            data_tag_write_bus    <= '0;
            data_tag_parity_out   <= '0;
            dRamWe                <= 1'b0;
        end else begin
            iRamWe <= ramWrite && !isData_reg;
            dRamWe <= ramWrite && isData_reg;
            instr_data_write_bus  <= fifoOut[63:0];
            instr_data_parity_out <= dPar;
            instr_tag_write_bus   <= tagIn;
            instr_tag_parity_out  <= tPar;
            data_data_write_bus   <= fifoOut[63:0];
            data_data_parity_out  <= dPar;
            data_tag_write_bus    <= tagIn;
            data_tag_parity_out   <= tPar;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    AST_ZERO_IN_RESET: assert property (@(posedge core_clk)
        sys_rst |=> (data_data_write_bus == '0 && instr_tag_write_bus == '0 && !dRamWe))
        else $error("RAM bus not zero in reset");
    AST_DPAR_ODD: assert property (@(posedge core_clk) disable iff (sys_rst)
        dRamWe |-> ^{data_data_write_bus[7:0], data_data_parity_out[0]} == 1'b1)
        else $error("data parity not odd");
    AST_TPAR_ODD: assert property (@(posedge core_clk) disable iff (sys_rst)
        dRamWe |-> ^{data_tag_write_bus[21:16], data_tag_parity_out[2]} == 1'b1)
        else $error("tag parity not odd");
    AST_ZEROKB_NOWR: assert property (@(posedge core_clk) disable iff (sys_rst)
        (dZeroKb && strapDone_reg) |=> !dRamWe)
        else $error("0KB data cache wrote RAM");
    AST_ABORT_INVAL: assert property (@(posedge core_clk) disable iff (sys_rst)
        (beatTake && lastBeat && (abortSeen_reg || beatAbort)) |=> !lineValid)
        else $error("aborted line left valid");
    AST_FOUR_BEATS: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_reg == ST_FILL && state_next == ST_DONE) |-> lastBeat)
        else $error("fill ended early");
    AST_DABORT: assert property (@(posedge core_clk) disable iff (sys_rst)
        (sigAbort && isData_reg) |=> (dPreciseAbort && data_fault_address_reg == $past(addr_reg)))
        else $error("data abort not precise");
    AST_PREF_NOABT: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_reg == ST_FILL && isPref_reg) |=> !iPreciseAbort)
        else $error("prefetch raised abort");
    AST_IMPRECISE: assert property (@(posedge core_clk) disable iff (sys_rst)
        (castoutDone && castoutAbort ##1 dAccessValid) |=> dImpreciseAbort)
        else $error("castout abort lost");
    COV_FILL: cover property (@(posedge core_clk) fillDone && lineValid);
    COV_ABORT: cover property (@(posedge core_clk) dPreciseAbort);
    COV_CAST: cover property (@(posedge core_clk) castoutStart);
    COV_BUF: cover property (@(posedge core_clk) bufServe);
endmodule

/* File: fill_fifo.sv */
/*
 * Small FIFO between the bus interface unit and the linefill logic.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/100ps
module fill_fifo #(
    parameter int W     = 65,
    parameter int DEPTH = 4
) (
    input  wire logic         core_clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] inData,
    input  wire logic         inValid,
    output wire logic         inReady,
    output wire logic [W-1:0] outData,
    output wire logic         outValid,
    input  wire logic         outReady
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wrPtr_reg;
    logic [AW-1:0] rdPtr_reg;
    logic [AW:0]   count_reg;
    wire           doWr = inValid && inReady;
    wire           doRd = outValid && outReady;
    ////////////////////////////////////////////////////////////////////////
    // Honest flags from the occupancy count
    assign inReady  = count_reg != (AW+1)'(DEPTH);
    assign outValid = count_reg != '0;
    assign outData  = mem[rdPtr_reg];
    // Pointers wrap only at power-of-two depths
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (doWr) wrPtr_reg <= wrPtr_reg + AW'(1);
            if (doRd) rdPtr_reg <= rdPtr_reg + AW'(1);
            count_reg <= count_reg + (AW+1)'(doWr) - (AW+1)'(doRd);
        end
    end
    // Storage carries no reset
    always_ff @(posedge core_clk) begin
        if (doWr) mem[wrPtr_reg] <= inData;
    end
endmodule

/* File: parity_gen.sv */
/*
 * Odd parity per byte of a write bus, combinational.
 * Assumes the bus width is a multiple of eight or has one short top field.
 */
`timescale 1ns/100ps
module parity_gen
    import cache_ctrl_pkg::*;
#(
    parameter int W = 64
) (
    input  wire logic [W-1:0]         busIn,
    output wire logic [(W+7)/8-1:0]   parOut
);
    localparam int N = (W + 7) / 8;
    ////////////////////////////////////////////////////////////////////////
    // One bit per byte; short top field covers what is left
    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : gByte
            localparam int HI = (8 * g + 7 < W) ? 8 * g + 7 : W - 1;
            assign parOut[g] = ~(^busIn[HI:8*g]);
        end
    endgenerate
endmodule

/* File: tb.sv */
/*
 * Self-checking bench for the cache size, abort and parity controller.
 * Assumes the partner model answers fills; inputs change at falling edges.
 */
`timescale 1ns/100ps
module tb
    import cache_ctrl_pkg::*;
;
    logic core_clk = 1'b0, sys_rst = 1'b1, go = 1'b0, slow = 1'b0, coAbort = 1'b0;
    logic [3:0] data_cache_size_strap = 4'h5, instr_cache_size_strap = 4'h3, abortMask = 4'h0;
    logic dFillReq = 1'b0, iFillReq = 1'b0, iFillIsPrefetch = 1'b0, fillHitBuf = 1'b0;
    logic iExecuted = 1'b0, victimValid = 1'b0, victimDirty = 1'b0, cleanReq = 1'b0;
    logic castoutDone = 1'b0, castoutAbort = 1'b0, dAccessValid = 1'b0;
    logic [31:0] fillAddr = 32'h0;
    logic [21:0] tagIn = 22'h2a_5c3e;
    logic [63:0] beatBase = 64'h0123_4567_89ab_cdef;
    wire logic [3:0]  dIdxWidth, iIdxWidth;
    wire logic        biuBeatReady, biuBeatAbort, biuBeatValid, dZeroKb, iZeroKb, fillBusy;
    wire logic        fillDone, lineValid, bufServe, dPreciseAbort, iPreciseAbort;
    wire logic        dImpreciseAbort, castoutStart, iRamWe, dRamWe;
    wire logic [31:0] data_fault_address_reg, instr_fault_address_reg;
    wire logic [21:0] instr_tag_write_bus, data_tag_write_bus;
    wire logic [2:0]  instr_tag_parity_out, data_tag_parity_out;
    wire logic [63:0] biuBeatData, instr_data_write_bus, data_data_write_bus;
    wire logic [7:0]  instr_data_parity_out, data_data_parity_out;
    wire logic [7:0]  ev = {fillDone, dRamWe, iRamWe, dPreciseAbort, iPreciseAbort,
                            dImpreciseAbort, castoutStart, bufServe};
    int cnt [8];
    int parErrs;
    int fail_count = 0, samples_checked = 0, cycles = 0;
    ////////////////////////////////////////////////////////////////////////////
    cache_size_abort_parity_ctrl #(.FIFO_DEPTH(4)) dut (.*);
    biu_model partner (.core_clk(core_clk), .sys_rst(sys_rst), .go(go), .slow(slow),
        .abortMask(abortMask), .base(beatBase), .biuBeatReady(biuBeatReady),
        .ramWe(dRamWe), .ramData(data_data_write_bus), .ramPar(data_data_parity_out),
        .biuBeatData(biuBeatData), .biuBeatAbort(biuBeatAbort),
        .biuBeatValid(biuBeatValid), .parErrs(parErrs));
    ////////////////////////////////////////////////////////////////////////////
    // Odd parity: each byte plus its bit holds an odd count of ones
    function automatic logic [7:0] oddPar(input logic [63:0] d);
        for (int i = 0; i < 8; i++) oddPar[i] = ~^d[8*i+:8];
    endfunction
    function automatic logic [2:0] tagPar(input logic [21:0] t);
        return {~^t[21:16], ~^t[15:8], ~^t[7:0]};
    endfunction
    function automatic logic [3:0] idxW(input logic [3:0] c);
        return (c >= 4'h3 && c <= 4'h8) ? c + 4'h2 : 4'h0;
    endfunction
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cc(input string what, input int k, input int exp);
        check(what, 64'(cnt[k]), 64'(exp));
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Clock, cycle ceiling, and a monitor that checks every RAM write
    initial forever #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            end_of_test();
        end
    end
    always @(negedge core_clk) begin
        castoutDone = (castoutStart === 1'b1);     // Castout finishes next cycle
        castoutAbort = castoutDone && coAbort;
        if (!sys_rst && dRamWe === 1'b1) begin
            check("dData", data_data_write_bus, beatBase + 64'(cnt[6]));
            check("dPar", 64'(data_data_parity_out), 64'(oddPar(data_data_write_bus)));
            check("dTagPar", 64'(data_tag_parity_out), 64'(tagPar(data_tag_write_bus)));
        end
        if (!sys_rst && iRamWe === 1'b1) begin
            check("iData", instr_data_write_bus, beatBase + 64'(cnt[5]));
            check("iPar", 64'(instr_data_parity_out), 64'(oddPar(instr_data_write_bus)));
            check("iTagPar", 64'(instr_tag_parity_out), 64'(tagPar(instr_tag_write_bus)));
        end
        for (int k = 0; k < 8; k++) if (!sys_rst && ev[k] === 1'b1) cnt[k]++;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Shared drivers: reset pulse and one linefill of four beats
    task automatic rst(input int n);
        @(negedge core_clk) sys_rst = 1'b1;
        repeat (n) @(negedge core_clk);
        sys_rst = 1'b0;
        repeat (3) @(negedge core_clk);
    endtask
    task automatic fill(input logic isD, input logic pre, input logic [31:0] a,
                        input logic [3:0] m);
        cnt = '{default: 0};
        beatBase = beatBase ^ 64'h9e37_79b9_7f4a_7c15;
        abortMask = m;
        @(negedge core_clk);
        dFillReq = isD;
        iFillReq = !isD;
        iFillIsPrefetch = pre;
        fillAddr = a;
        go = 1'b1;
        @(negedge core_clk);
        dFillReq = 1'b0;
        iFillReq = 1'b0;
        cleanReq = 1'b0;
        check("busy", 64'(fillBusy), 64'h1);
        go = 1'b0;
        for (int n = 0; n < 40 && cnt[7] == 0; n++) @(negedge core_clk);
        repeat (3) @(negedge core_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        repeat (3) @(negedge core_clk);
        check("ramZero", 64'(|{data_data_write_bus, instr_data_write_bus, data_tag_write_bus,
            instr_tag_write_bus, data_data_parity_out, instr_data_parity_out,
            data_tag_parity_out, instr_tag_parity_out, dRamWe, iRamWe}), 64'h0);
        check("rstInvalid", 64'(lineValid), 64'h0);
        repeat (2) @(negedge core_clk);
        sys_rst = 1'b0;
    endtask
    task automatic t_sizes();
        for (int c = 0; c < 16; c++) begin
            data_cache_size_strap = 4'(c);
            instr_cache_size_strap = 4'(15 - c);
            rst(2);
            check("dIdx", 64'(dIdxWidth), 64'(idxW(4'(c))));
            check("iIdx", 64'(iIdxWidth), 64'(idxW(4'(15 - c))));
            check("dZero", 64'(dZeroKb), 64'(idxW(4'(c)) == 4'h0));
            check("iZero", 64'(iZeroKb), 64'(idxW(4'(15 - c)) == 4'h0));
            data_cache_size_strap = 4'(c + 1);
            @(negedge core_clk);
            check("idxHeld", 64'(dIdxWidth), 64'(idxW(4'(c))));
        end
    endtask
    task automatic t_fill();
        victimValid = 1'b1;
        fill(1'b1, 1'b0, 32'h0000_1040, 4'h0);
        cc("dWrites", 6, 4);
        cc("dDone", 7, 1);
        cc("cleanVictim", 1, 0);
        check("dValid", 64'(lineValid), 64'h1);
        victimDirty = 1'b1;
        slow = 1'b1;
        fill(1'b1, 1'b0, 32'h0000_2080, 4'h0);
        cc("slowWrites", 6, 4);
        cc("dirtyCast", 1, 1);
        slow = 1'b0;
    endtask
    task automatic t_abort();
        fill(1'b1, 1'b0, 32'h0000_3000, 4'h1);
        cc("firstAbort", 4, 1);
        check("data_fault_address_reg", 64'(data_fault_address_reg), 64'h3000);
        cc("noRamWr", 6, 0);
        check("voided", 64'(lineValid), 64'h0);
        fill(1'b1, 1'b0, 32'h0000_3100, 4'h4);
        cc("lateAbort", 4, 1);
        check("lateFar", 64'(data_fault_address_reg), 64'h3100);
        check("partWr", 64'(cnt[6] > 2), 64'h0);
        check("voided2", 64'(lineValid), 64'h0);
        fill(1'b1, 1'b0, 32'h0000_3100, 4'h0);
        cc("refill", 6, 4);
    endtask
    task automatic t_ifill();
        fill(1'b0, 1'b0, 32'h0000_4000, 4'h1);
        cc("iNotRun", 3, 0);
        cc("iNoCast", 1, 0);
        iExecuted = 1'b1;
        fill(1'b0, 1'b0, 32'h0000_4100, 4'h1);
        cc("iRun", 3, 1);
        check("instr_fault_address_reg", 64'(instr_fault_address_reg), 64'h4100);
        fill(1'b0, 1'b1, 32'h0000_4200, 4'h2);
        cc("pfNoAbort", 3, 0);
        check("pfVoid", 64'(lineValid), 64'h0);
        fill(1'b0, 1'b0, 32'h0000_4300, 4'h0);
        cc("iWrites", 5, 4);
        victimDirty = 1'b0;
    endtask
    task automatic t_castout();
        victimValid = 1'b0;
        cleanReq = 1'b1;
        coAbort = 1'b1;
        fill(1'b1, 1'b0, 32'h0000_5000, 4'h0);
        cc("cleanCast", 1, 1);
        cc("noEarly", 2, 0);
        repeat (2) begin
            dAccessValid = 1'b1;
            @(negedge core_clk);
            dAccessValid = 1'b0;
            repeat (3) @(negedge core_clk);
            cc("impOnce", 2, 1);
        end
        check("noAddr", 64'(data_fault_address_reg), 64'h3100);
        // Data access right after an aborted castout
        cnt = '{default: 0};
        cleanReq = 1'b1;
        repeat (2) @(negedge core_clk);
        cleanReq = 1'b0;
        dAccessValid = 1'b1;
        @(negedge core_clk);
        dAccessValid = 1'b0;
        @(negedge core_clk);
        cc("impNext", 2, 1);
        coAbort = 1'b0;
    endtask
    task automatic t_zero();
        data_cache_size_strap = 4'h0;
        rst(1);
        fill(1'b1, 1'b0, 32'h0000_6000, 4'h0);
        cc("zkbNoWr", 6, 0);
        cc("zkbDone", 7, 1);
        check("zkbValid", 64'(lineValid), 64'h1);
        cnt = '{default: 0};
        fillHitBuf = 1'b1;
        dFillReq = 1'b1;
        @(negedge core_clk);
        dFillReq = 1'b0;
        fillHitBuf = 1'b0;
        repeat (3) @(negedge core_clk);
        cc("bufServe", 0, 1);
        cc("noRefill", 7, 0);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        t_reset();
        t_sizes();
        data_cache_size_strap = 4'h5;
        instr_cache_size_strap = 4'h3;
        rst(1);
        t_fill();
        t_abort();
        t_ifill();
        t_castout();
        check("parStore", 64'(parErrs), 64'h0);
        t_zero();
        end_of_test();
    end
endmodule
